// File: rtl/tovd_pkg.sv
// constants, types and register map of the three-operand vector alu decoder
package tovd_pkg;
  // ==========================================================
  // instruction word layout
  localparam logic [5:0] FMT_PATTERN = 6'h34;
  localparam int FMT_LSB     = 26;
  localparam int OPC_LSB     = 16;
  localparam int OPC_W       = 10;
  localparam int VEC_DEST_LSB = 0;
  localparam int SCL_DEST_LSB = 8;
  localparam int CLAMP_BIT   = 15;
  localparam int SEL_W       = 9;
  localparam int SRC_N       = 3;
  localparam int OSCALE_LSB  = 27;
  // ==========================================================
  // opcodes that use the scalar-result layout
  localparam logic [9:0] OPC_ADD_CO      = 10'h119;
  localparam logic [9:0] OPC_SUBBREV_CO  = 10'h11e;
  localparam logic [9:0] OPC_DIV_SCALE_S = 10'h1e0;
  localparam logic [9:0] OPC_DIV_SCALE_D = 10'h1e1;
  localparam logic [9:0] OPC_MAD_U64     = 10'h1e8;
  localparam logic [9:0] OPC_MAD_I64     = 10'h1e9;
  // ==========================================================
  // operand selector boundaries
  localparam logic [8:0] SEL_SREG_LAST = 9'h065;
  localparam logic [8:0] SEL_SCRATCH   = 9'h066;
  localparam logic [8:0] SEL_RETRY     = 9'h068;
  localparam logic [8:0] SEL_COND      = 9'h06a;
  localparam logic [8:0] SEL_TRAP      = 9'h06c;
  localparam logic [8:0] SEL_TRAP_LAST = 9'h07b;
  localparam logic [8:0] SEL_MEMHELP   = 9'h07c;
  localparam logic [8:0] SEL_LANE      = 9'h07e;
  localparam logic [8:0] SEL_ZERO      = 9'h080;
  localparam logic [8:0] SEL_POS_LAST  = 9'h0c0;
  localparam logic [8:0] SEL_NEG_LAST  = 9'h0d0;
  localparam logic [8:0] SEL_APER      = 9'h0eb;
  localparam logic [8:0] SEL_APER_LAST = 9'h0ee;
  localparam logic [8:0] SEL_WAVE      = 9'h0ef;
  localparam logic [8:0] SEL_FLT       = 9'h0f0;
  localparam logic [8:0] SEL_FLT_LAST  = 9'h0f8;
  localparam logic [8:0] SEL_SUBDW     = 9'h0f9;
  localparam logic [8:0] SEL_DPAR      = 9'h0fa;
  localparam logic [8:0] SEL_FLAG      = 9'h0fb;
  localparam logic [8:0] SEL_FLAG_LAST = 9'h0fd;
  localparam logic [8:0] SEL_LIT       = 9'h0ff;
  // inline float constants, selector order
  localparam logic [31:0] FLT_TABLE [9] = '{32'h3f000000, 32'hbf000000, 32'h3f800000,
    32'hbf800000, 32'h40000000, 32'hc0000000, 32'h40800000, 32'hc0800000, 32'h3e22f983};
  // ==========================================================
  // register byte addresses and stride, plus the inf/nan exponent
  localparam logic [7:0] A_INSN_LO = 8'h00;
  localparam logic [7:0] A_INSN_HI = 8'h04;
  localparam logic [7:0] A_FIELDS  = 8'h08;
  localparam logic [7:0] A_SRC_INFO = 8'h0c;
  localparam logic [7:0] A_RESULT  = 8'h24;
  localparam logic [7:0] A_SCALED  = 8'h28;
  localparam logic [7:0] SRC_STRIDE = 8'h08;
  localparam logic [7:0] EXP_INF   = 8'hff;
  // ==========================================================
  typedef enum logic [4:0] {
    SRC_SREG = 5'h00, SRC_SCRATCH = 5'h01, SRC_RETRY = 5'h02, SRC_COND = 5'h03,
    SRC_TRAP = 5'h04, SRC_MEMHELP = 5'h05, SRC_LANE = 5'h06, SRC_INT = 5'h07,
    SRC_APER = 5'h08, SRC_WAVE = 5'h09, SRC_FLT = 5'h0a, SRC_SUBDW = 5'h0b,
    SRC_DPAR = 5'h0c, SRC_FLAG = 5'h0d, SRC_LIT = 5'h0e, SRC_VREG = 5'h0f,
    SRC_RSVD = 5'h10
  } tovd_cls_t;
  typedef struct packed {
    tovd_cls_t   cls;
    logic [7:0]  idx;
    logic [31:0] val;
  } tovd_src_t;
endpackage

// File: rtl/tovd_decoder.sv
// three-operand vector alu instruction decoder behind a wishbone slave
`timescale 1ns/1ps
module tovd_decoder
  import tovd_pkg::*;
#(
  parameter int ADR_W = 8
) (
  input  wire logic             core_clk_in,
  input  wire logic             rst_in,
  input  wire logic             wb_cyc_in,
  input  wire logic             wb_stb_in,
  input  wire logic             wb_we_in,
  input  wire logic [ADR_W-1:0] wb_adr_in,
  input  wire logic [3:0]       wb_sel_in,
  input  wire logic [31:0]      wb_dat_in,
  output logic                  wb_ack_out,
  output logic [31:0]           wb_dat_out,
  output logic                  fmt_valid_out
);
  // ==========================================================
  // elaboration check
  if (ADR_W < 8) begin : g_adr_chk
    $error("ADR_W must be at least 8");
  end

  // ==========================================================
  // state
  logic [31:0] insn_lo, insn_hi, result, scaled;
  logic        go, fmt_ok, scal, clamp;
  logic [7:0]  vec_dest;
  logic [6:0]  scl_dest;
  logic [1:0]  oscale;
  logic [9:0]  opc;
  logic [8:0]  sel [SRC_N];
  tovd_src_t   src [SRC_N];
  logic [31:0] next_insn_lo, next_insn_hi, next_result, next_scaled, next_dat;
  logic        next_go, next_fmt_ok, next_scal, next_clamp, next_ack;
  logic [7:0]  next_vec_dest;
  logic [6:0]  next_scl_dest;
  logic [1:0]  next_oscale;
  logic [9:0]  next_opc;
  logic [8:0]  next_sel [SRC_N];
  tovd_src_t   next_src [SRC_N];
  logic        wr, is_scal;
  logic [7:0]  adr;
  logic [9:0]  cur_opc;

  // byte-lane merge for writes
  function automatic logic [31:0] merge(logic [31:0] old, logic [31:0] d, logic [3:0] be);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (be[b]) begin
        r[b*8 +: 8] = d[b*8 +: 8];
      end
    end
    return r;
  endfunction

  // one selector to class, index and constant value
  function automatic tovd_src_t decode_src(logic [8:0] s);
    tovd_src_t   d;
    logic [31:0] sx;
    d  = '0;
    sx = {23'h0, s};
    d.cls = SRC_RSVD;
    if (s[8]) begin
      d.cls = SRC_VREG;
      d.idx = s[7:0];
    end else if (s <= SEL_SREG_LAST) begin
      d.cls = SRC_SREG;
      d.idx = s[7:0];
    end else if (s < SEL_RETRY) begin
      d.cls = SRC_SCRATCH;
      d.idx = {7'h0, s[0]};
    end else if (s < SEL_COND) begin
      d.cls = SRC_RETRY;
      d.idx = {7'h0, s[0]};
    end else if (s < SEL_TRAP) begin
      d.cls = SRC_COND;
      d.idx = {7'h0, s[0]};
    end else if (s <= SEL_TRAP_LAST) begin
      d.cls = SRC_TRAP;
      d.idx = 8'(s - SEL_TRAP);
    end else if (s == SEL_MEMHELP) begin
      d.cls = SRC_MEMHELP;
    end else if (s == SEL_LANE || s == SEL_LANE + 9'h001) begin
      d.cls = SRC_LANE;
      d.idx = {7'h0, s[0]};
    end else if (s >= SEL_ZERO && s <= SEL_POS_LAST) begin
      d.cls = SRC_INT;
      d.val = sx - {23'h0, SEL_ZERO};
    end else if (s > SEL_POS_LAST && s <= SEL_NEG_LAST) begin
      d.cls = SRC_INT;
      d.val = {23'h0, SEL_POS_LAST} - sx;
    end else if (s >= SEL_APER && s <= SEL_APER_LAST) begin
      d.cls = SRC_APER;
      d.idx = 8'(s - SEL_APER);
    end else if (s == SEL_WAVE) begin
      d.cls = SRC_WAVE;
    end else if (s >= SEL_FLT && s <= SEL_FLT_LAST) begin
      d.cls = SRC_FLT;
      d.val = FLT_TABLE[4'(s - SEL_FLT)];
    end else if (s == SEL_SUBDW) begin
      d.cls = SRC_SUBDW;
    end else if (s == SEL_DPAR) begin
      d.cls = SRC_DPAR;
    end else if (s >= SEL_FLAG && s <= SEL_FLAG_LAST) begin
      d.cls = SRC_FLAG;
      d.idx = 8'(s - SEL_FLAG);
    end else if (s == SEL_LIT) begin
      d.cls = SRC_LIT;
    end
    return d;
  endfunction

  // ==========================================================
  // bus slave and decode, next values
  // ack is registered, so every access answers one cycle after the request
  always_comb begin
    adr          = wb_adr_in[7:0];
    wr           = wb_cyc_in && wb_stb_in && wb_we_in && wb_ack_out;
    next_ack     = wb_cyc_in && wb_stb_in && !wb_ack_out;
    next_insn_lo = (wr && adr == A_INSN_LO) ? merge(insn_lo, wb_dat_in, wb_sel_in) : insn_lo;
    next_insn_hi = (wr && adr == A_INSN_HI) ? merge(insn_hi, wb_dat_in, wb_sel_in) : insn_hi;
    next_result  = (wr && adr == A_RESULT) ? merge(result, wb_dat_in, wb_sel_in) : result;
    next_go      = wr && adr == A_INSN_HI;                    // decode one edge after a write to the high word
    cur_opc      = insn_lo[OPC_LSB +: OPC_W];
    is_scal      = (cur_opc >= OPC_ADD_CO && cur_opc <= OPC_SUBBREV_CO) ||
                   cur_opc == OPC_DIV_SCALE_S || cur_opc == OPC_DIV_SCALE_D ||
                   cur_opc == OPC_MAD_U64 || cur_opc == OPC_MAD_I64;
    next_fmt_ok  = fmt_ok;
    next_scal    = scal;
    next_vec_dest = vec_dest;
    next_scl_dest = scl_dest;
    next_clamp    = clamp;
    next_oscale   = oscale;
    next_opc     = opc;
    for (int i = 0; i < SRC_N; i++) begin
      next_sel[i] = sel[i];
      next_src[i] = src[i];
    end
    if (go) begin
      next_fmt_ok = insn_lo[FMT_LSB +: 6] == FMT_PATTERN;
      next_vec_dest = insn_lo[VEC_DEST_LSB +: 8];
      next_clamp    = insn_lo[CLAMP_BIT];
      next_scal     = is_scal;
      next_scl_dest = is_scal ? insn_lo[SCL_DEST_LSB +: 7] : 7'h00;
      next_oscale   = insn_hi[OSCALE_LSB +: 2];
      next_opc    = cur_opc;
      for (int i = 0; i < SRC_N; i++) begin
        next_sel[i] = insn_hi[i*SEL_W +: SEL_W];
        next_src[i] = decode_src(insn_hi[i*SEL_W +: SEL_W]);
      end
    end
    // output modifier on a single-float result by exponent step;
    // zero, denormal, inf and nan pass unchanged, overflow is not caught
    next_scaled = result;
    if (result[30:23] != 8'h00 && result[30:23] != EXP_INF) begin
      case (oscale)
        2'h1:    next_scaled[30:23] = result[30:23] + 8'h01;
        2'h2:    next_scaled[30:23] = result[30:23] + 8'h02;
        2'h3:    next_scaled[30:23] = result[30:23] - 8'h01;
        default: next_scaled = result;
      endcase
    end
    // read mux on address bits 7:0 only; unmapped offsets there read zero
    next_dat = 32'h0;
    if (adr == A_INSN_LO) next_dat = insn_lo;
    if (adr == A_INSN_HI) next_dat = insn_hi;
    if (adr == A_FIELDS) begin
      next_dat = {2'h0, opc, scal, fmt_ok, oscale, clamp, scl_dest, vec_dest};
    end
    for (int i = 0; i < SRC_N; i++) begin
      if (adr == A_SRC_INFO + 8'(i) * SRC_STRIDE) begin
        next_dat = {7'h0, sel[i], src[i].idx, 3'h0, src[i].cls};
      end
      if (adr == A_SRC_INFO + 8'(i) * SRC_STRIDE + 8'h04) next_dat = src[i].val;
    end
    if (adr == A_RESULT) next_dat = result;
    if (adr == A_SCALED) next_dat = scaled;
    if (!next_ack) next_dat = wb_dat_out;
  end

  // registers only
  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      wb_ack_out    <= 1'b0;
      wb_dat_out    <= 32'h0;
      fmt_valid_out <= 1'b0;
      insn_lo <= 32'h0;
      insn_hi <= 32'h0;
      result  <= 32'h0;
      scaled  <= 32'h0;
      go      <= 1'b0;
      fmt_ok  <= 1'b0;
      scal    <= 1'b0;
      vec_dest <= 8'h00;
      scl_dest <= 7'h00;
      clamp    <= 1'b0;
      oscale   <= 2'h0;
      opc     <= 10'h000;
      for (int i = 0; i < SRC_N; i++) begin
        sel[i] <= 9'h000;
        src[i] <= '0;
      end
    end else begin
      wb_ack_out    <= next_ack;
      wb_dat_out    <= next_dat;
      fmt_valid_out <= next_fmt_ok;
      insn_lo <= next_insn_lo;
      insn_hi <= next_insn_hi;
      result  <= next_result;
      scaled  <= next_scaled;
      go      <= next_go;
      fmt_ok  <= next_fmt_ok;
      scal    <= next_scal;
      vec_dest <= next_vec_dest;
      scl_dest <= next_scl_dest;
      clamp    <= next_clamp;
      oscale   <= next_oscale;
      opc     <= next_opc;
      for (int i = 0; i < SRC_N; i++) begin
        sel[i] <= next_sel[i];
        src[i] <= next_src[i];
      end
    end
  end

  // ==========================================================
  // assertions
  default clocking cb @(posedge core_clk_in); endclocking
  default disable iff (rst_in);

  property p_fmt;
    go |=> fmt_ok == ($past(insn_lo[31:26]) == 6'h34) && vec_dest == $past(insn_lo[7:0])
           && clamp == $past(insn_lo[15]);
  endproperty
  a_fmt: assert property (p_fmt) else $error("format, destination or clamp wrong");

  property p_scl_dest;
    go && is_scal |=> scal && scl_dest == $past(insn_lo[14:8]);
  endproperty
  a_scl_dest: assert property (p_scl_dest) else $error("scalar destination wrong");

  property p_layout;
    go && !(insn_lo[25:16] inside {10'd480, 10'd481, 10'd488, 10'd489, [10'd281:10'd286]})
      |=> !scal && scl_dest == 7'h00;
  endproperty
  a_layout: assert property (p_layout) else $error("general layout not used");

  property p_sel;
    go |=> sel[0] == $past(insn_hi[8:0]) && sel[1] == $past(insn_hi[17:9])
           && sel[2] == $past(insn_hi[26:18]);
  endproperty
  a_sel: assert property (p_sel) else $error("selector fields wrong");

  property p_gpr;
    go ##1 (sel[1] < 9'd102 || sel[1] > 9'd255)
      |-> src[1].idx == sel[1][7:0] && src[1].cls == (sel[1][8] ? SRC_VREG : SRC_SREG);
  endproperty
  a_gpr: assert property (p_gpr) else $error("register selector wrong");

  property p_special;
    $rose(sel[1] == 9'd124) || $rose(sel[1] == 9'd127) |->
      src[1].cls == (sel[1] == 9'd124 ? SRC_MEMHELP : SRC_LANE);
  endproperty
  a_special: assert property (p_special) else $error("special selector wrong");

  property p_trap;
    sel[2] inside {[9'd108:9'd123]} |-> src[2].cls == SRC_TRAP
      && src[2].idx == 8'(sel[2] - 9'd108);
  endproperty
  a_trap: assert property (p_trap) else $error("trap temporary wrong");

  property p_int;
    sel[0] inside {[9'd128:9'd208]} |-> src[0].cls == SRC_INT && $signed(src[0].val) ==
      (sel[0] <= 9'd192 ? int'(sel[0]) - 128 : 192 - int'(sel[0]));
  endproperty
  a_int: assert property (p_int) else $error("inline integer wrong");

  property p_aper;
    go ##1 (sel[0] inside {[9'd235:9'd239]}) |-> src[0].cls ==
      (sel[0] == 9'd239 ? SRC_WAVE : SRC_APER) && (sel[0] == 9'd239 || src[0].idx < 8'd4);
  endproperty
  a_aper: assert property (p_aper) else $error("window selector wrong");

  // scaled follows result one edge late, so compare against the result it was built from
  property p_oscale;
    oscale == 2'h3 && result[30:23] > 8'h01 && result[30:23] != 8'hff && $stable(result)
      |=> scaled[30:23] == $past(result[30:23]) - 8'h01
          && scaled[22:0] == $past(result[22:0]);
  endproperty
  a_oscale: assert property (p_oscale) else $error("output modifier wrong");

  property p_flt;
    sel[2] == 9'd242 || sel[2] == 9'd248 |->
      src[2].val == (sel[2] == 9'd242 ? 32'h3f800000 : 32'h3e22f983);
  endproperty
  a_flt: assert property (p_flt) else $error("inline float wrong");

  property p_rsvd;
    go ##1 (sel[0] inside {9'd125, [9'd209:9'd234], 9'd254}) |-> src[0].cls == SRC_RSVD;
  endproperty
  a_rsvd: assert property (p_rsvd) else $error("reserved selector not flagged");

  c_scal: cover property (go ##1 scal && fmt_ok);
  c_lit:  cover property (go ##1 src[0].cls == SRC_LIT);
  c_read: cover property (wb_cyc_in && !wb_we_in ##1 wb_ack_out);
endmodule // tovd_decoder

// File: dv/tovd_issue_model.sv
// issue-stage model that hands instruction words to the decoder over wishbone
`timescale 1ns/1ps
module tovd_issue_model (
  input  wire logic        core_clk_in,
  input  wire logic        wb_ack_in,
  input  wire logic [31:0] wb_dat_in,
  output logic             wb_cyc_out,
  output logic             wb_stb_out,
  output logic             wb_we_out,
  output logic [7:0]       wb_adr_out,
  output logic [3:0]       wb_sel_out,
  output logic [31:0]      wb_dat_out
);
  // ==========================================================
  // idle bus at time zero
  initial begin
    wb_cyc_out = 1'b0;
    wb_stb_out = 1'b0;
    wb_we_out  = 1'b0;
    wb_adr_out = 8'h00;
    wb_sel_out = 4'h0;
    wb_dat_out = 32'h0000_0000;
  end
  // ==========================================================
  // reserved selectors are never placed in an issued word
  function automatic bit issuable(input logic [8:0] s);
    return !(s == 9'd125 || (s >= 9'd209 && s <= 9'd234) || s == 9'd254);
  endfunction
  // ==========================================================
  // one classic cycle; ok stays low if no ack within the bound
  task automatic bus(input logic we, input logic [7:0] adr, input logic [31:0] dat,
                     input logic [3:0] sel, output logic [31:0] rd, output bit ok);
    int n;
    @(posedge core_clk_in);
    wb_cyc_out <= 1'b1;
    wb_stb_out <= 1'b1;
    wb_we_out  <= we;
    wb_adr_out <= adr;
    wb_sel_out <= sel;
    wb_dat_out <= dat;
    ok = 1'b0;
    for (n = 0; n < 16 && !ok; n++) begin
      @(posedge core_clk_in);
      ok = (wb_ack_in === 1'b1); // pre-edge value, no race with the slave
    end
    rd = wb_dat_in;
    wb_cyc_out <= 1'b0;
    wb_stb_out <= 1'b0;
    wb_dat_out <= ~dat; // released data and address lines never keep the last value; we and sel do
    wb_adr_out <= ~adr;
  endtask
endmodule // tovd_issue_model

// File: dv/tovd_decoder_tb_top.sv
// self-checking bench for the decoder register interface
`timescale 1ns/1ps
module tovd_decoder_tb_top import tovd_pkg::*;;
  logic        core_clk_in;
  logic        rst_in;
  logic        wb_cyc, wb_stb, wb_we, wb_ack, fmt_valid, scl, ci, cv;
  logic [3:0]  wb_sel;
  logic [7:0]  wb_adr;
  logic [31:0] wb_wdat, wb_rdat, r, hi, v;
  int          mismatches, num_checks, k, cls, idx;
  logic [31:0] flt_exp [9] = '{32'h3f000000, 32'hbf000000, 32'h3f800000, 32'hbf800000,
    32'h40000000, 32'hc0000000, 32'h40800000, 32'hc0800000, 32'h3e22f983};
  logic [31:0] om_exp [4] = '{32'h3f800000, 32'h40000000, 32'h40800000, 32'h3f000000};
  logic [9:0]  opc_list [16] = '{10'd281, 10'd282, 10'd283, 10'd284, 10'd285, 10'd286,
    10'd480, 10'd481, 10'd488, 10'd489, 10'd280, 10'd287, 10'd482, 10'd487, 10'd490, 10'd448};

  tovd_decoder u_dut (.core_clk_in(core_clk_in), .rst_in(rst_in), .wb_cyc_in(wb_cyc),
    .wb_stb_in(wb_stb), .wb_we_in(wb_we), .wb_adr_in(wb_adr), .wb_sel_in(wb_sel),
    .wb_dat_in(wb_wdat), .wb_ack_out(wb_ack), .wb_dat_out(wb_rdat),
    .fmt_valid_out(fmt_valid));
  tovd_issue_model u_issue (.core_clk_in(core_clk_in), .wb_ack_in(wb_ack),
    .wb_dat_in(wb_rdat), .wb_cyc_out(wb_cyc), .wb_stb_out(wb_stb), .wb_we_out(wb_we),
    .wb_adr_out(wb_adr), .wb_sel_out(wb_sel), .wb_dat_out(wb_wdat));

  // ==========================================================
  // 200 MHz clock
  initial begin
    core_clk_in = 1'b0;
    forever #2.5 core_clk_in = ~core_clk_in;
  end
  // ==========================================================
  // verdict and checking helpers
  task automatic complete_run();
    if (mismatches == 0 && num_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // a missing ack ends the run at once
  task automatic acc(input logic we, input logic [7:0] a, input logic [31:0] d,
                     input logic [3:0] s, output logic [31:0] rd);
    bit ok;
    u_issue.bus(we, a, d, s, rd, ok);
    if (!ok) begin
      mismatches++;
      complete_run();
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] rd;
    acc(1'b1, a, d, 4'hf, rd);
  endtask
  task automatic rd_chk(input string nm, input logic [7:0] a, input logic [31:0] exp,
                        input logic [31:0] mask);
    logic [31:0] rd;
    acc(1'b0, a, 32'h0, 4'h0, rd);
    check(nm, rd & mask, exp);
  endtask
  // fields become readable two edges after the high-word ack
  task automatic decode(input logic [31:0] lo, input logic [31:0] hw);
    wr(A_INSN_LO, lo);
    wr(A_INSN_HI, hw);
    repeat (2) @(posedge core_clk_in);
  endtask
  // expected class, index and value of one selector
  task automatic exp_sel(input int s);
    ci = 1'b1; cv = 1'b0; idx = 0; v = 32'h0;
    if (s <= 101) begin cls = 0; idx = s; end
    else if (s <= 105) begin cls = (s < 104) ? 1 : 2; idx = s & 1; end
    else if (s <= 107) begin cls = 3; idx = s - 106; end
    else if (s <= 123) begin cls = 4; idx = s - 108; end
    else if (s == 124) begin cls = 5; ci = 1'b0; end
    else if (s <= 127) begin cls = 6; idx = s - 126; end
    else if (s <= 208) begin cls = 7; ci = 1'b0; cv = 1'b1; v = (s <= 192) ? s - 128 : 192 - s; end
    else if (s <= 238) begin cls = 8; idx = s - 235; end
    else if (s == 239) begin cls = 9; ci = 1'b0; end
    else if (s <= 248) begin cls = 10; ci = 1'b0; cv = 1'b1; v = flt_exp[s-240]; end
    else if (s <= 250) begin cls = s - 238; ci = 1'b0; end
    else if (s <= 253) begin cls = 13; idx = s - 251; end
    else if (s == 255) begin cls = 14; ci = 1'b0; end
    else begin cls = 15; idx = s - 256; end
  endtask
  // ==========================================================
  // main sequence
  initial begin
    rst_in = 1'b1;
    mismatches = 0;
    num_checks = 0;
    repeat (8) @(posedge core_clk_in);
    rst_in <= 1'b0;
    // reset state, read-only, unmapped and byte lanes
    rd_chk("fields_rst", A_FIELDS, 32'h0, '1);
    check("fmt_valid_rst", {31'b0, fmt_valid}, 32'h0);
    wr(A_INSN_LO, 32'hd1c0_80a5);
    rd_chk("insn_lo", A_INSN_LO, 32'hd1c0_80a5, '1);
    wr(A_FIELDS, '1);
    rd_chk("fields_ro", A_FIELDS, 32'h0, '1);
    wr(8'h40, 32'h1234_5678);
    rd_chk("unmapped", 8'h40, 32'h0, '1);
    acc(1'b1, A_RESULT, '1, 4'hf, r);
    acc(1'b1, A_RESULT, 32'h0, 4'b0010, r);
    rd_chk("byte_lanes", A_RESULT, 32'hffff_00ff, '1);
    // layout choice per opcode, boundaries either side except below 480
    foreach (opc_list[i]) begin
      scl = (i < 10);
      decode({6'b110100, opc_list[i], 1'b1, 7'h5a, 8'hc3}, {3'b0, 2'b01, 27'h4010001});
      rd_chk("fields", A_FIELDS, {2'b0, opc_list[i], scl, 1'b1, 2'b01, 1'b1,
        scl ? 7'h5a : 7'h00, 8'hc3}, 32'h3fff_ffff);
      check("fmt_valid", {31'b0, fmt_valid}, 32'h1);
    end
    // wrong pattern in the top six bits
    decode({6'b110101, 26'h0}, 32'h0);
    rd_chk("fmt_bad", A_FIELDS, 32'h0, 32'h0004_0000);
    check("fmt_valid_bad", {31'b0, fmt_valid}, 32'h0);
    // every issuable selector, rotated through the three slots
    for (int s = 0; s < 512; s++) begin
      if (!u_issue.issuable(s[8:0])) continue;
      k = s % 3;
      hi = {5'b0, 9'h100, 9'h100, 9'h100};
      hi[k*9 +: 9] = s[8:0];
      decode({6'b110100, 10'd448, 16'h0}, hi);
      exp_sel(s);
      rd_chk("src_info", 8'(8'h0c + 8 * k), {7'b0, s[8:0], ci ? idx[7:0] : 8'h0, 3'b0,
        cls[4:0]}, ci ? 32'h01ff_ff1f : 32'h01ff_001f);
      if (cv) rd_chk("src_val", 8'(8'h10 + 8 * k), v, '1);
    end
    // output modifier on a known result
    for (int om = 0; om < 4; om++) begin
      decode({6'b110100, 10'd448, 16'h0}, {3'b0, 2'(om), 27'h0});
      wr(A_RESULT, 32'h3f80_0000);
      rd_chk("scaled", A_SCALED, om_exp[om], '1);
    end
    complete_run();
  end
endmodule // tovd_decoder_tb_top
